/* File: tol_coil_model.sv */
// Purpose: Valve solenoid driver and coil ground sense model
// Assumes: Coil grounds LAG cycles after the command while armed
// Notes:   Sense drops LAG cycles after command or both arm supplies go
`default_nettype none

module tol_coil_model #(
    parameter int unsigned LAG = 2
) (
    // Clock
    input wire logic clk,
    // Driver side
    input wire logic ignitionCmd,
    input wire logic armA,
    input wire logic armB,
    // Sense back to the logic
    output logic ignSense
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pipe = 8'h00;
    // Unpowered driver cannot ground the coil
    always @(posedge clk) begin
        pipe <= {pipe[6:0], ignitionCmd & (armA | armB)};
    end
    assign ignSense = pipe[LAG-1];
endmodule

`default_nettype wire

/* File: tol_delay.sv */
// Purpose: Constants and carriers for the thrust on-off logic, plus the one-second
//          edge delay used for the delayed ignition signals.
// Assumes: Single 20 MHz clock, synchronous active-high reset.
// Notes:   A pending change is cancelled whenever its input returns before expiry.
`default_nettype none

package tol_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned ONE_SEC_NS = 1000000000;
    localparam int unsigned ONE_SEC_CYC = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 25;

    // ==========================================================
    // Reset values
    localparam logic RST_LEVEL = 1'b0;
    localparam logic [CNT_W-1:0] CNT_RST = 25'h0000000;

    // ==========================================================
    // Panel and link inputs, as sampled
    typedef struct packed {
        logic settlePb;
        logic handlePlusX;
        logic handleCw;
        logic srcBackup;
        logic ignitePb;
        logic emEnable;
        logic computerThrustN;
        logic armA;
        logic armB;
        logic ignSense;
    } tol_in_t;

    localparam tol_in_t IN_RST = '{default: 1'b0, computerThrustN: 1'b1};

    typedef struct packed {
        logic out;
        logic [CNT_W-1:0] cnt;
    } tol_dly_state_t;
endpackage

module tol_delay #(
    parameter bit DELAY_RISE = 1'b1,
    parameter bit DELAY_FALL = 1'b1,
    parameter int unsigned CYCLES = tol_pkg::ONE_SEC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Level in, delayed level out
    input wire logic levelIn,
    output logic levelOut
);
    localparam logic [tol_pkg::CNT_W-1:0] LAST = tol_pkg::CNT_W'(CYCLES - 1);

    tol_pkg::tol_dly_state_t s_reg;
    tol_pkg::tol_dly_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (levelIn == s_reg.out) begin
            // An input that returns before expiry cancels the pending change
            s_next.cnt = tol_pkg::CNT_RST;
        end else if (!(levelIn ? DELAY_RISE : DELAY_FALL) || s_reg.cnt == LAST) begin
            s_next.out = levelIn;
            s_next.cnt = tol_pkg::CNT_RST;
        end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '{out: tol_pkg::RST_LEVEL, cnt: tol_pkg::CNT_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign levelOut = s_reg.out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_delay_expiry: assert property (
        (levelIn != s_reg.out && s_reg.cnt == LAST) |=> (s_reg.out == $past(levelIn)))
        else $error("delayed level did not follow at expiry");
    a_delay_early: assert property (
        ($changed(s_reg.out) && (s_reg.out ? DELAY_RISE : DELAY_FALL))
            |-> ($past(s_reg.cnt) == LAST))
        else $error("delayed level changed before its count ran out");
endmodule

`default_nettype wire

/* File: tol_thrust_logic.sv */
// Purpose: Main engine thrust on-off sequencing with latch-up and delayed ignition signals.
// Assumes: All panel, computer, monitor and coil-sense inputs are asynchronous to clk.
// Notes:   Ignition command drives the solenoid driver that grounds the valve coil.
`default_nettype none

// Functional notes
// - Backup ignite needs +X, pushbutton, monitor enable
// - Sensed ignition latches burn after releases
// - Monitor enable withdrawn drops backup ignition
// - Computer-to-backup handover keeps burn via latch
// - Both arm switches off stop thrust
// - +X is settling button OR handle +X
// - Settling button drives direct jets, inhibits pitch/yaw
// - Handle +X keeps hold, overlap cut at 1s
// - Thrust lamp follows sensed coil ground
// - Coil ground yields jet inhibit, steering holds
// - Jet inhibit 1s after on, 1s after off
// - Steering holds immediate on, off 1s late
// - Separate auto and manual steering holds
// - Computer low requests thrust when selected
// - Backup selected by selector or handle clockwise
module tol_thrust_logic #(
    parameter int unsigned ONE_SEC_CYCLES = tol_pkg::ONE_SEC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Crew panel
    input wire logic settlePb,
    input wire logic handlePlusX,
    input wire logic handleCw,
    input wire logic srcBackup,
    input wire logic ignitePb,
    input wire logic armA,
    input wire logic armB,
    // Guidance computer and entry monitor
    input wire logic computerThrustN,
    input wire logic emEnable,
    // Valve coil ground sense
    input wire logic ignSense,
    // Solenoid driver and lamp
    output logic ignitionCmd,
    output logic thrustLamp,
    // Attitude jets
    output logic directJetCmd,
    output logic pitchYawInhibit,
    output logic attitudeHold,
    output logic handleJetCmd,
    output logic jetInhibitDelayed,
    // Steering electronics
    output logic steerHoldAuto,
    output logic steerHoldManual
);
    // ==========================================================
    // State
    typedef struct packed {
        tol_pkg::tol_in_t sync1;
        tol_pkg::tol_in_t sync2;
        tol_pkg::tol_in_t sync3;
        tol_pkg::tol_in_t filt;
        logic ignCmd;
        logic latch;
        logic lamp;
        logic directJet;
        logic pyInhibit;
        logic attHold;
        logic handleJet;
    } tol_state_t;

    localparam tol_state_t ST_RST = '{
        sync1: tol_pkg::IN_RST,
        sync2: tol_pkg::IN_RST,
        sync3: tol_pkg::IN_RST,
        filt: tol_pkg::IN_RST,
        default: 1'b0
    };

    tol_state_t s_reg;
    tol_state_t s_next;
    tol_pkg::tol_in_t pins;
    logic plusX;
    logic backupSel;
    logic armAny;
    logic computerOn;
    logic backupOn;
    logic latchHold;
    logic overlapCut;

    assign pins = '{
        settlePb: settlePb,
        handlePlusX: handlePlusX,
        handleCw: handleCw,
        srcBackup: srcBackup,
        ignitePb: ignitePb,
        emEnable: emEnable,
        computerThrustN: computerThrustN,
        armA: armA,
        armB: armB,
        ignSense: ignSense
    };

    // ==========================================================
    // Thrust equations
    always_comb begin
        plusX = s_reg.filt.settlePb | s_reg.filt.handlePlusX;
        backupSel = s_reg.filt.srcBackup | s_reg.filt.handleCw;
        armAny = s_reg.filt.armA | s_reg.filt.armB;
        computerOn = !backupSel && !s_reg.filt.computerThrustN;
        // Monitor enable is trusted to be absent on negative velocity
        backupOn = backupSel && plusX && s_reg.filt.ignitePb && s_reg.filt.emEnable;
        // Latch survives a handover from the computer enable loss drops it
        latchHold = backupSel && s_reg.latch && s_reg.filt.emEnable;
    end

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        // A change is believed only once two later stages agree
        if (s_reg.sync2 == s_reg.sync3) begin
            s_next.filt = s_reg.sync3;
        end
        s_next.ignCmd = armAny && (computerOn || backupOn || latchHold);
        // Latch arms only on sensed coil ground while commanding
        s_next.latch = s_next.ignCmd && (s_reg.latch || s_reg.filt.ignSense);
        s_next.lamp = s_reg.filt.ignSense;
        s_next.directJet = s_reg.filt.settlePb;
        s_next.pyInhibit = s_reg.filt.settlePb;
        s_next.attHold = !s_reg.filt.settlePb;
        // Handle ullage is cut once ignition has been sensed for one second
        s_next.handleJet = s_reg.filt.handlePlusX && !overlapCut;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Delayed ignition signals
    tol_delay #(.DELAY_RISE(1'b1), .DELAY_FALL(1'b0), .CYCLES(ONE_SEC_CYCLES)) uOverlap (
        .clk(clk), .sys_rst(sys_rst), .levelIn(s_reg.filt.ignSense), .levelOut(overlapCut)
    );
    tol_delay #(.DELAY_RISE(1'b1), .DELAY_FALL(1'b1), .CYCLES(ONE_SEC_CYCLES)) uJetInh (
        .clk(clk), .sys_rst(sys_rst), .levelIn(s_reg.filt.ignSense),
        .levelOut(jetInhibitDelayed)
    );
    tol_delay #(.DELAY_RISE(1'b0), .DELAY_FALL(1'b1), .CYCLES(ONE_SEC_CYCLES)) uSteerAuto (
        .clk(clk), .sys_rst(sys_rst), .levelIn(s_reg.filt.ignSense), .levelOut(steerHoldAuto)
    );
    tol_delay #(.DELAY_RISE(1'b0), .DELAY_FALL(1'b1), .CYCLES(ONE_SEC_CYCLES)) uSteerMan (
        .clk(clk), .sys_rst(sys_rst), .levelIn(s_reg.filt.ignSense),
        .levelOut(steerHoldManual)
    );

    assign ignitionCmd = s_reg.ignCmd;
    assign thrustLamp = s_reg.lamp;
    assign directJetCmd = s_reg.directJet;
    assign pitchYawInhibit = s_reg.pyInhibit;
    assign attitudeHold = s_reg.attHold;
    assign handleJetCmd = s_reg.handleJet;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence armedOff;
        !armAny;
    endsequence
    sequence latchedBurn;
        latchHold && armAny;
    endsequence
    // Burn that is still being commanded, with the latch already set
    sequence computerBurnLatched;
        ignitionCmd && s_reg.latch && armAny && (computerOn || latchHold);
    endsequence
    sequence backupTakesOver;
        backupSel && s_reg.filt.emEnable && armAny;
    endsequence

    a_ign_cause: assert property (
        $rose(ignitionCmd) |-> $past(computerOn || backupOn || latchHold))
        else $error("ignition rose without a thrust-on term");
    a_latch_hold: assert property (
        latchedBurn |=> ignitionCmd)
        else $error("latched burn was not held");
    a_enable_drop: assert property (
        (backupSel && !s_reg.filt.emEnable && !computerOn) |=> !ignitionCmd)
        else $error("ignition held after monitor enable loss");
    a_backup_handover: assert property (
        (computerBurnLatched ##1 backupTakesOver) |=> ignitionCmd)
        else $error("burn lost on handover to backup");
    // Latch is checked one cycle later, with the command: arm switches may come back after that
    a_arm_off: assert property (
        armedOff |=> (!ignitionCmd && !s_reg.latch))
        else $error("thrust not stopped with arm switches off");
    a_settle_jets: assert property (
        s_reg.filt.settlePb |=> (directJetCmd && pitchYawInhibit && !attitudeHold))
        else $error("settling button did not drive direct jets");
    a_lamp_follow: assert property (
        ##1 thrustLamp == $past(s_reg.filt.ignSense))
        else $error("lamp does not follow coil ground");
    a_steer_on: assert property (
        $rose(s_reg.filt.ignSense) |=> (steerHoldAuto && steerHoldManual))
        else $error("steering holds not immediate");
    // A re-ignition inside a pending off delay keeps jet inhibit up on purpose
    a_jet_late: assert property (
        ($rose(s_reg.filt.ignSense) && !jetInhibitDelayed) |=> !jetInhibitDelayed)
        else $error("jet inhibit rose without its delay");
    a_computer_on: assert property (
        (computerOn && armAny) |=> ignitionCmd)
        else $error("computer thrust request ignored");
endmodule

`default_nettype wire

/* File: tol_thrust_logic_tb_top.sv */
// Purpose: Scenario bench for the thrust on-off logic
// Assumes: One-second delays shortened to SEC cycles
// Notes:   Checks allow for the input synchroniser latency
`default_nettype none

module tol_thrust_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SEC = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    tol_pkg::tol_in_t pin = tol_pkg::IN_RST;
    logic ignSense, ignitionCmd, thrustLamp, directJetCmd, pitchYawInhibit;
    logic attitudeHold, handleJetCmd, jetInhibitDelayed, steerHoldAuto, steerHoldManual;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    // ==========================================================
    // Design and coil model
    tol_thrust_logic #(.ONE_SEC_CYCLES(SEC)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .settlePb(pin.settlePb),
        .handlePlusX(pin.handlePlusX), .handleCw(pin.handleCw),
        .srcBackup(pin.srcBackup), .ignitePb(pin.ignitePb), .armA(pin.armA),
        .armB(pin.armB), .computerThrustN(pin.computerThrustN),
        .emEnable(pin.emEnable), .ignSense(ignSense), .ignitionCmd(ignitionCmd),
        .thrustLamp(thrustLamp), .directJetCmd(directJetCmd),
        .pitchYawInhibit(pitchYawInhibit), .attitudeHold(attitudeHold),
        .handleJetCmd(handleJetCmd), .jetInhibitDelayed(jetInhibitDelayed),
        .steerHoldAuto(steerHoldAuto), .steerHoldManual(steerHoldManual)
    );
    tol_coil_model coil_u (
        .clk(clk), .ignitionCmd(ignitionCmd), .armA(pin.armA), .armB(pin.armB),
        .ignSense(ignSense)
    );

    // ==========================================================
    // Helpers
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Whole run needs well under 400 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic t_settle();
        pin.srcBackup = 1'b1;
        pin.ignitePb = 1'b1;
        pin.emEnable = 1'b1;
        pin.armA = 1'b1;
        w(10);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        pin.settlePb = 1'b1;
        w(8);
        chk("ignitionCmd", 1'b1, ignitionCmd);
        chk("pitchYawInhibit", 1'b1, pitchYawInhibit);
        chk("attitudeHold", 1'b0, attitudeHold);
        w(SEC + 10);
        chk("directJetCmd", 1'b1, directJetCmd);
        pin.settlePb = 1'b0;
        pin.emEnable = 1'b0;
        w(SEC + 40);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        // Monitor withholding its enable keeps the ignite button dead
        pin.settlePb = 1'b1;
        w(8);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        chk("directJetCmd", 1'b1, directJetCmd);
        pin.settlePb = 1'b0;
        w(8);
        chk("directJetCmd", 1'b0, directJetCmd);
        chk("pitchYawInhibit", 1'b0, pitchYawInhibit);
        chk("attitudeHold", 1'b1, attitudeHold);
    endtask
    task automatic t_handle();
        pin.emEnable = 1'b1;
        pin.handlePlusX = 1'b1;
        w(14);
        chk("thrustLamp", 1'b1, thrustLamp);
        chk("steerHoldAuto", 1'b1, steerHoldAuto);
        chk("steerHoldManual", 1'b1, steerHoldManual);
        chk("jetInhibitDelayed", 1'b0, jetInhibitDelayed);
        chk("handleJetCmd", 1'b1, handleJetCmd);
        chk("attitudeHold", 1'b1, attitudeHold);
        w(SEC - 4);
        chk("jetInhibitDelayed", 1'b0, jetInhibitDelayed);
        chk("handleJetCmd", 1'b1, handleJetCmd);
        w(10);
        chk("jetInhibitDelayed", 1'b1, jetInhibitDelayed);
        chk("handleJetCmd", 1'b0, handleJetCmd);
        pin.ignitePb = 1'b0;
        pin.handlePlusX = 1'b0;
        w(10);
        chk("ignitionCmd", 1'b1, ignitionCmd);
        pin.emEnable = 1'b0;
        w(14);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        chk("thrustLamp", 1'b0, thrustLamp);
        chk("steerHoldAuto", 1'b1, steerHoldAuto);
        chk("jetInhibitDelayed", 1'b1, jetInhibitDelayed);
        w(SEC + 4);
        chk("steerHoldManual", 1'b0, steerHoldManual);
        chk("steerHoldAuto", 1'b0, steerHoldAuto);
        chk("jetInhibitDelayed", 1'b0, jetInhibitDelayed);
    endtask
    task automatic t_computer();
        pin.srcBackup = 1'b0;
        pin.armB = 1'b1;
        pin.computerThrustN = 1'b0;
        w(20);
        chk("ignitionCmd", 1'b1, ignitionCmd);
        pin.emEnable = 1'b1;
        pin.handleCw = 1'b1;
        pin.computerThrustN = 1'b1;
        w(10);
        chk("ignitionCmd", 1'b1, ignitionCmd);
        pin.armA = 1'b0;
        pin.armB = 1'b0;
        w(12);
        chk("ignitionCmd", 1'b0, ignitionCmd);
    endtask
    // Reset in mid-burn, after the re-ignition has cancelled the off delays from the last burn
    task automatic t_reset();
        pin.armA = 1'b1;
        pin.ignitePb = 1'b1;
        pin.handlePlusX = 1'b1;
        w(14);
        pin.ignitePb = 1'b0;
        pin.handlePlusX = 1'b0;
        w(8);
        chk("ignitionCmd", 1'b1, ignitionCmd);
        sys_rst = 1'b1;
        w(3);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        chk("thrustLamp", 1'b0, thrustLamp);
        chk("steerHoldAuto", 1'b0, steerHoldAuto);
        chk("jetInhibitDelayed", 1'b0, jetInhibitDelayed);
        sys_rst = 1'b0;
        w(12);
        chk("ignitionCmd", 1'b0, ignitionCmd);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        w(5);
        chk("ignitionCmd", 1'b0, ignitionCmd);
        chk("steerHoldAuto", 1'b0, steerHoldAuto);
        chk("jetInhibitDelayed", 1'b0, jetInhibitDelayed);
        sys_rst = 1'b0;
        w(2);
        t_settle();
        t_handle();
        t_computer();
        t_reset();
        give_verdict();
    end
endmodule

`default_nettype wire
